// ### logic/fsc_pkg.sv
// Constants for the flash status and configuration register bank.
// Assumes a 20 MHz system clock and a serial host well below it.
package fsc_pkg;
    // ----------------------------------------
    // Clock and busy time
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_OP_NS       = 10000;
    localparam int OP_CYCLES     = (T_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_RDSR1  = 8'h05;
    localparam logic [7:0] OP_RDSR2  = 8'h35;
    localparam logic [7:0] OP_RDSR3  = 8'h15;
    localparam logic [7:0] OP_WRSR1  = 8'h01;
    localparam logic [7:0] OP_WRSR2  = 8'h31;
    localparam logic [7:0] OP_WRSR3  = 8'h11;
    localparam logic [7:0] OP_PP     = 8'h02;
    localparam logic [7:0] OP_QPP    = 8'h32;
    localparam logic [7:0] OP_SE     = 8'h20;
    localparam logic [7:0] OP_BE32   = 8'h52;
    localparam logic [7:0] OP_BE64   = 8'hD8;
    localparam logic [7:0] OP_CE     = 8'hC7;
    localparam logic [7:0] OP_SECE   = 8'h44;
    localparam logic [7:0] OP_SECP   = 8'h42;
    localparam logic [7:0] OP_SUSP   = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_QUAD   = 8'h38;
    localparam logic [7:0] OP_QEXIT  = 8'hFF;
    localparam logic [7:0] PFX_ONE   = 8'hAA;
    localparam logic [7:0] PFX_TWO   = 8'h55;
    // ----------------------------------------
    // Field positions within each status byte
    // ----------------------------------------
    localparam int B1_BUSY = 0;
    localparam int B1_WEL  = 1;
    localparam int B1_BP0  = 2;
    localparam int B1_TB   = 5;
    localparam int B1_SEC  = 6;
    localparam int B1_SRP  = 7;
    localparam int B2_SRL  = 0;
    localparam int B2_QE   = 1;
    localparam int B2_LB1  = 3;
    localparam int B2_CMP  = 6;
    localparam int B2_SUS  = 7;
    localparam int B3_WPS  = 2;
    localparam int B3_DRIVE_STRENGTH_BIT0 = 5;
    localparam int B3_HRST = 7;
    // ----------------------------------------
    // Reset values, drive percentages and busy count
    // ----------------------------------------
    localparam logic [1:0] DRV_RESET = 2'h3;
    localparam logic [6:0] PCT_100   = 7'h64;
    localparam logic [6:0] PCT_75    = 7'h4B;
    localparam logic [6:0] PCT_50    = 7'h32;
    localparam logic [6:0] PCT_25    = 7'h19;
    localparam logic [15:0] OP_COUNT = 16'(OP_CYCLES);
    // ----------------------------------------
    // Frame phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        FSC_IDLE = 2'b00,
        FSC_OPC  = 2'b01,
        FSC_ARG  = 2'b11
    } fsc_ph_t;
endpackage

// ### logic/fsc_regs.sv
// Status and configuration register bank of a serial NOR flash.
// Assumes a mode 0 serial host whose clock is far slower than i_clk.
// Operation
// R1: Progress flag is set while program, erase or status write runs.
// R2: While busy, only status reads and suspend are obeyed.
// R3: Progress flag clears when the operation finishes.
// R4: Write enable instruction sets the write enable latch.
// R5: Latch clears on power-up, write disable, program, erase, status write.
// R6: Three block protect bits are writable, default zero.
// R7: Top/bottom select chooses protection from top or bottom.
// R8: Unit select picks 4KB sectors or 64KB blocks.
// R9: Complement bit inverts the protected region.
// R10: Status protect and status lock bits are stored.
// R11: Both clear: pin ignored, write needs latch set.
// R12: Protect set, lock clear: low protect pin refuses status writes.
// R13: Lock set blocks status writes until next power cycle.
// R14: Prefix AAh then 55h makes status protection permanent; here reset clears it.
// R15: Suspend sets paused flag; resume or power cycle clears it.
// R16: Three security lock bits are one-time settable, default zero; here reset clears them.
// R17: Quad enable turns protect and pause pins into data lines.
// R18: Enter quad command mode is ignored unless quad enable set.
// R19: In four-wire mode quad enable cannot be cleared.
// R20: Scheme select chooses protect bits or individual block locks.
// R21: Every individual block lock is set after reset.
// R22: Drive bits decode to 100, 75, 50 or 25 percent.
// R23: Reserved bits read zero and writes to them do nothing.
// R24: Pin select picks pause or reset function while quad enable clear.
// R25: A refused status write leaves all contents unchanged.
module fsc_regs (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    input  wire logic       i_cs_n,
    input  wire logic       i_sclk,
    input  wire logic       i_di,
    input  wire logic       i_wp_n,
    output logic            o_do,
    output logic            o_do_oe,
    output logic            o_busy,
    output logic            o_quad_enable,
    output logic            o_four_wire_mode,
    output logic            o_wp_pin_active,
    output logic            o_pause_pin_active,
    output logic            o_reset_pin_active,
    output logic            o_use_block_locks,
    output logic [5:0]      o_region_cfg,
    output logic [2:0]      o_security_lock,
    output logic            o_block_locks_set,
    output logic [6:0]      o_drive_pct
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]      cs;
        logic [2:0]      sck;
        logic [1:0]      di;
        logic [1:0]      wp;
        fsc_pkg::fsc_ph_t ph;
        logic [2:0]      cnt;
        logic [7:0]      sh;
        logic [7:0]      opc;
        logic [7:0]      arg;
        logic [1:0]      nargs;
        logic [7:0]      tx;
        logic            do_q;
        logic            doe;
        logic            busy;
        logic            write_enable_latch;
        logic [2:0]      bp;
        logic            tb;
        logic            sec;
        logic            status_protect;
        logic            status_lock;
        logic            qe;
        logic [2:0]      lb;
        logic            cmp;
        logic            paused_op_flag;
        logic            protect_scheme_select;
        logic [1:0]      drv;
        logic            hrst;
        logic            quad;
        logic            otp;
        logic [1:0]      pre;
        logic [15:0]     tmr;
        logic            pins_wp;
        logic            pins_pause;
        logic            pins_rst;
        logic [5:0]      region;
        logic [6:0]      pct;
        logic            bls;
    } fsc_st_t;

    fsc_st_t r;
    fsc_st_t n;

    // ----------------------------------------
    // Decoders
    // ----------------------------------------
    function automatic logic [7:0] status_byte(input fsc_st_t s, input logic [7:0] op);
        logic [7:0] v;
        v = 8'h00;
        unique case (op)
            fsc_pkg::OP_RDSR1: begin
                v[fsc_pkg::B1_BUSY] = s.busy;
                v[fsc_pkg::B1_WEL] = s.write_enable_latch;
                v[fsc_pkg::B1_BP0 +: 3] = s.bp;
                v[fsc_pkg::B1_TB] = s.tb;
                v[fsc_pkg::B1_SEC] = s.sec;
                v[fsc_pkg::B1_SRP] = s.status_protect;
            end
            fsc_pkg::OP_RDSR2: begin
                v[fsc_pkg::B2_SRL] = s.status_lock;
                v[fsc_pkg::B2_QE] = s.qe;
                v[fsc_pkg::B2_LB1 +: 3] = s.lb;
                v[fsc_pkg::B2_CMP] = s.cmp;
                v[fsc_pkg::B2_SUS] = s.paused_op_flag;
            end
            default: begin
                v[fsc_pkg::B3_WPS] = s.protect_scheme_select;
                v[fsc_pkg::B3_DRIVE_STRENGTH_BIT0 +: 2] = s.drv;
                v[fsc_pkg::B3_HRST] = s.hrst;
            end
        endcase
        return v;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return op == fsc_pkg::OP_RDSR1 || op == fsc_pkg::OP_RDSR2 || op == fsc_pkg::OP_RDSR3;
    endfunction

    function automatic logic is_array_op(input logic [7:0] op);
        return op == fsc_pkg::OP_PP || op == fsc_pkg::OP_QPP || op == fsc_pkg::OP_SE
            || op == fsc_pkg::OP_BE32 || op == fsc_pkg::OP_BE64 || op == fsc_pkg::OP_CE
            || op == fsc_pkg::OP_SECE || op == fsc_pkg::OP_SECP;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic       rise;
        logic       fall;
        logic [7:0] b;
        logic       wr_ok;
        logic       wr_cmd;
        n = r;
        n.cs = {r.cs[0], i_cs_n};
        n.sck = {r.sck[1:0], i_sclk};
        n.di = {r.di[0], i_di};
        n.wp = {r.wp[0], i_wp_n};
        rise = r.sck[1] && !r.sck[2];
        fall = !r.sck[1] && r.sck[2];
        b = {r.sh[6:0], r.di[1]};
        // Pin gating only applies while the protect pin is not a data line.
        wr_ok = r.write_enable_latch && !r.status_lock && !r.otp                            // R11 R13 R14
             && !(r.status_protect && !r.wp[1] && !r.qe);                       // R12 R17
        wr_cmd = r.nargs == 2'h1 && r.cnt == 3'h0;
        if (r.busy) begin
            if (r.tmr <= 16'h0001) begin
                n.busy = 1'b0;                                       // R3
                n.tmr = 16'h0000;
            end else begin
                n.tmr = r.tmr - 16'h0001;
            end
        end
        unique case (r.ph)
            fsc_pkg::FSC_IDLE: begin
                if (!r.cs[1]) begin
                    n.ph = fsc_pkg::FSC_OPC;
                    n.cnt = 3'h0;
                    n.nargs = 2'h0;
                end
            end
            fsc_pkg::FSC_OPC,
            fsc_pkg::FSC_ARG: begin
                if (r.cs[1]) begin
                    n.ph = fsc_pkg::FSC_IDLE;
                    n.doe = 1'b0;
                    if (r.ph == fsc_pkg::FSC_ARG && r.cnt == 3'h0) begin
                        n.pre = 2'h0;
                        if (r.busy || r.paused_op_flag) begin                   // R2
                            if (r.opc == fsc_pkg::OP_SUSP && r.busy) begin
                                n.paused_op_flag = 1'b1;                        // R15
                                n.busy = 1'b0;
                            end else if (r.opc == fsc_pkg::OP_RESUME && r.paused_op_flag) begin
                                n.paused_op_flag = 1'b0;                        // R15
                                n.busy = 1'b1;
                            end else if (r.opc == fsc_pkg::OP_WREN && !r.busy) begin
                                n.write_enable_latch = 1'b1;
                            end
                        end else if (r.opc == fsc_pkg::OP_WREN) begin
                            n.write_enable_latch = 1'b1;                            // R4
                        end else if (r.opc == fsc_pkg::OP_WRDI) begin
                            n.write_enable_latch = 1'b0;                            // R5
                        end else if (is_array_op(r.opc) && r.write_enable_latch) begin
                            n.write_enable_latch = 1'b0;                            // R5
                            n.busy = 1'b1;                           // R1
                            n.tmr = fsc_pkg::OP_COUNT;
                        end else if (r.opc == fsc_pkg::OP_QUAD) begin
                            n.quad = r.qe;                           // R18
                        end else if (r.opc == fsc_pkg::OP_QEXIT) begin
                            n.quad = 1'b0;
                        end else if (r.opc == fsc_pkg::PFX_ONE) begin
                            n.pre = 2'h1;
                        end else if (r.opc == fsc_pkg::PFX_TWO && r.pre == 2'h1) begin
                            n.pre = 2'h2;                            // R14
                        end else if (wr_cmd && wr_ok) begin          // R25
                            n.write_enable_latch = 1'b0;                            // R5
                            n.busy = 1'b1;                           // R1
                            n.tmr = fsc_pkg::OP_COUNT;
                            unique case (r.opc)
                                fsc_pkg::OP_WRSR1: begin
                                    n.bp = r.arg[fsc_pkg::B1_BP0 +: 3]; // R6
                                    n.tb = r.arg[fsc_pkg::B1_TB];    // R7
                                    n.sec = r.arg[fsc_pkg::B1_SEC];  // R8
                                    n.status_protect = r.arg[fsc_pkg::B1_SRP];  // R10
                                end
                                fsc_pkg::OP_WRSR2: begin
                                    n.status_lock = r.arg[fsc_pkg::B2_SRL];  // R10
                                    n.otp = r.pre == 2'h2 && r.arg[fsc_pkg::B2_SRL]; // R14
                                    n.qe = r.arg[fsc_pkg::B2_QE] || r.quad; // R19
                                    n.lb = r.lb | r.arg[fsc_pkg::B2_LB1 +: 3]; // R16
                                    n.cmp = r.arg[fsc_pkg::B2_CMP];  // R9
                                end
                                fsc_pkg::OP_WRSR3: begin
                                    n.protect_scheme_select = r.arg[fsc_pkg::B3_WPS];  // R20
                                    n.drv = r.arg[fsc_pkg::B3_DRIVE_STRENGTH_BIT0 +: 2];
                                    n.hrst = r.arg[fsc_pkg::B3_HRST];
                                end
                                default: begin
                                    n.busy = 1'b0;
                                    n.write_enable_latch = r.write_enable_latch;
                                    n.tmr = r.tmr;
                                end
                            endcase
                        end
                    end
                end else if (rise) begin
                    n.sh = b;
                    n.cnt = r.cnt + 3'h1;
                    if (r.cnt == 3'h7) begin
                        if (r.ph == fsc_pkg::FSC_OPC) begin
                            n.opc = b;
                            n.ph = fsc_pkg::FSC_ARG;
                            if (is_read(b)) begin
                                n.tx = status_byte(r, b);
                            end
                        end else begin
                            n.arg = r.nargs == 2'h0 ? b : r.arg;
                            n.nargs = r.nargs == 2'h3 ? r.nargs : r.nargs + 2'h1;
                            if (is_read(r.opc)) begin
                                n.tx = status_byte(r, r.opc);
                            end
                        end
                    end
                end else if (fall && r.ph == fsc_pkg::FSC_ARG && is_read(r.opc)) begin
                    n.do_q = r.tx[7];
                    n.doe = 1'b1;
                    n.tx = {r.tx[6:0], 1'b0};
                end
            end
            default: begin
                n.ph = fsc_pkg::FSC_IDLE;
            end
        endcase
        // Derived pin functions and protection view, registered for clean outputs.
        n.pins_wp = !r.qe && r.status_protect;                                  // R17
        n.pins_pause = !r.qe && !r.hrst;                             // R24
        n.pins_rst = !r.qe && r.hrst;                                // R24
        n.region = r.protect_scheme_select ? 6'h00 : {r.cmp, r.sec, r.tb, r.bp};       // R20
        // No unlock instruction exists here, so the locks stay set.
        n.bls = 1'b1;                                                // R21
        unique case (r.drv)                                          // R22
            2'h0: n.pct = fsc_pkg::PCT_100;
            2'h1: n.pct = fsc_pkg::PCT_75;
            2'h2: n.pct = fsc_pkg::PCT_50;
            2'h3: n.pct = fsc_pkg::PCT_25;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset stands for a power cycle, so status lock, security lock and suspend state return to zero here.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;                                                 // R5 R13 R15 R23
            r.cs <= 2'h3;
            r.drv <= fsc_pkg::DRV_RESET;
            r.pct <= fsc_pkg::PCT_25;
            r.pins_pause <= 1'b1;
            r.bls <= 1'b1;                                           // R21
        end else if (i_ce) begin
            r <= n;
        end
    end

    assign o_do = r.do_q;
    assign o_do_oe = r.doe;
    assign o_busy = r.busy;
    assign o_quad_enable = r.qe;
    assign o_four_wire_mode = r.quad;
    assign o_wp_pin_active = r.pins_wp;
    assign o_pause_pin_active = r.pins_pause;
    assign o_reset_pin_active = r.pins_rst;
    assign o_use_block_locks = r.protect_scheme_select;
    assign o_region_cfg = r.region;
    assign o_security_lock = r.lb;
    assign o_block_locks_set = r.bls;                                // R21
    assign o_drive_pct = r.pct;
endmodule

// ### sim/fsc_regs_assertions.sv
// Concurrent checks for the flash status register bank.
// Assumes it is bound to fsc_regs and sees only that module's ports.
module fsc_regs_chk (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_cs_n,
    input wire logic       o_do_oe,
    input wire logic       o_busy,
    input wire logic       o_quad_enable,
    input wire logic       o_four_wire_mode,
    input wire logic       o_wp_pin_active,
    input wire logic       o_pause_pin_active,
    input wire logic       o_reset_pin_active,
    input wire logic       o_use_block_locks,
    input wire logic [5:0] o_region_cfg,
    input wire logic [2:0] o_security_lock,
    input wire logic       o_block_locks_set,
    input wire logic [6:0] o_drive_pct
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // The bound is loose: a busy span lasts at most OP_COUNT cycles, and a suspend ends it early.
    busy_span_a: assert property ($rose(o_busy) |-> o_busy[*8] ##[1:600] !o_busy)
        else $error("busy span wrong");
    oe_frame_a: assert property (i_cs_n[*8] |-> !o_do_oe)
        else $error("output driven outside a frame");
    wp_func_a: assert property (o_wp_pin_active |-> !o_quad_enable)
        else $error("protect pin live with quad enable");
    shared_off_a: assert property (o_quad_enable && $past(o_quad_enable)
        |-> !o_pause_pin_active && !o_reset_pin_active) else $error("shared pin live");
    shared_one_a: assert property (!o_quad_enable && $past(!o_quad_enable)
        |-> o_pause_pin_active != o_reset_pin_active) else $error("shared pin function");
    quad_mode_a: assert property ($rose(o_four_wire_mode) |-> $past(o_quad_enable))
        else $error("four-wire mode without quad enable");
    qe_kept_a: assert property (o_four_wire_mode |-> o_quad_enable)
        else $error("quad enable lost in four-wire mode");
    region_off_a: assert property (o_use_block_locks && $past(o_use_block_locks)
        |-> o_region_cfg == 6'h00) else $error("region used under block locks");
    block_lock_a: assert property (o_block_locks_set)
        else $error("block locks not set");
    drive_code_a: assert property (o_drive_pct inside {7'h64, 7'h4B, 7'h32, 7'h19})
        else $error("drive strength out of table");
    sec_otp_a: assert property (($past(o_security_lock) & ~o_security_lock) == 3'h0)
        else $error("security lock cleared");
    busy_seen_c: cover property ($rose(o_busy));
    quad_seen_c: cover property ($rose(o_four_wire_mode));
    read_seen_c: cover property ($rose(o_do_oe));
endmodule
bind fsc_regs fsc_regs_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_n(i_cs_n),
    .o_do_oe(o_do_oe), .o_busy(o_busy), .o_quad_enable(o_quad_enable),
    .o_four_wire_mode(o_four_wire_mode), .o_wp_pin_active(o_wp_pin_active),
    .o_pause_pin_active(o_pause_pin_active), .o_reset_pin_active(o_reset_pin_active),
    .o_use_block_locks(o_use_block_locks), .o_region_cfg(o_region_cfg),
    .o_security_lock(o_security_lock), .o_block_locks_set(o_block_locks_set),
    .o_drive_pct(o_drive_pct));

// ### sim/fsc_host.sv
// Serial host model that frames instructions for the register bank.
// Assumes mode 0 and a serial clock of 400 ns made from i_clk falls.
module fsc_host (
    input  wire logic i_clk,
    input  wire logic i_do,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_di
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Frame driver
    // ----------------------------------------
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_di   = 1'b0;
    end
    // Sends an opcode and, if asked, one more byte; read data is sampled before each rise.
    task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input logic two,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {op, dat};
        rd = 8'h00;
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_clk);
        for (int i = 0; i < (two ? 16 : 8); i++) begin
            o_di = sh[15 - i];
            repeat (4) @(negedge i_clk);
            rd = {rd[6:0], i_do};
            o_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        // The line is inverted, so it no longer shows the last bit.
        o_di = ~o_di;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

// ### sim/test_fsc_regs.sv
// Self-checking bench for the flash status register bank.
// Assumes fsc_pkg, fsc_regs, the host model and the checker are compiled first.
module test_fsc_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_b, i_wp_n, cs_n, sclk, di, o_do, oe, busy, qe, fw, wpa, pza, rsa, ubl;
    logic [5:0] reg_cfg;
    logic [2:0] sec;
    logic       bls;
    logic [6:0] pct;
    logic [7:0] rd;
    int         failures, num_checks;
    fsc_regs DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_di(di), .i_wp_n(i_wp_n), .o_do(o_do), .o_do_oe(oe),
        .o_busy(busy), .o_quad_enable(qe), .o_four_wire_mode(fw), .o_wp_pin_active(wpa),
        .o_pause_pin_active(pza), .o_reset_pin_active(rsa), .o_use_block_locks(ubl),
        .o_region_cfg(reg_cfg), .o_security_lock(sec), .o_block_locks_set(bls),
        .o_drive_pct(pct));
    fsc_host host (.i_clk(i_clk), .i_do(o_do), .o_cs_n(cs_n), .o_sclk(sclk), .o_di(di));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        host.xfer(op, 8'h00, 1'b0, rd);
    endtask
    task automatic rsr(input logic [7:0] op, input logic [7:0] exp);
        host.xfer(op, 8'h00, 1'b1, rd);
        check(rd, exp);
    endtask
    task automatic wsr(input logic [7:0] op, input logic [7:0] dat);
        cmd(fsc_pkg::OP_WREN);
        host.xfer(op, dat, 1'b1, rd);
    endtask
    // A stuck busy flag is caught here rather than by the watchdog.
    task automatic wait_idle();
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge i_clk);
        check({7'h00, busy}, 8'h00);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #4000000;
        failures++;
        give_verdict();
    end
    initial begin
        i_rst_b = 1'b0;
        i_wp_n  = 1'b1;
        @(negedge i_clk);
        do_reset();
        rsr(fsc_pkg::OP_RDSR1, 8'h00);
        rsr(fsc_pkg::OP_RDSR2, 8'h00);
        rsr(fsc_pkg::OP_RDSR3, 8'h60);
        check({1'b0, pct}, 8'h19);
        check({6'h00, pza, bls}, 8'h03);
        host.xfer(fsc_pkg::OP_WRSR1, 8'h1C, 1'b1, rd);
        rsr(fsc_pkg::OP_RDSR1, 8'h00);
        cmd(fsc_pkg::OP_QUAD);
        check({7'h00, fw}, 8'h00);
        cmd(fsc_pkg::OP_WREN);
        rsr(fsc_pkg::OP_RDSR1, 8'h02);
        cmd(fsc_pkg::OP_WRDI);
        rsr(fsc_pkg::OP_RDSR1, 8'h00);
        $display("test defaults and latch done");
        wsr(fsc_pkg::OP_WRSR1, 8'h7C);
        check({7'h00, busy}, 8'h01);
        cmd(fsc_pkg::OP_WREN);
        rsr(fsc_pkg::OP_RDSR1, 8'h7D);
        wait_idle();
        rsr(fsc_pkg::OP_RDSR1, 8'h7C);
        check({2'b00, reg_cfg}, 8'h1F);
        wsr(fsc_pkg::OP_WRSR2, 8'h7A);
        wait_idle();
        rsr(fsc_pkg::OP_RDSR2, 8'h7A);
        check({2'b00, reg_cfg}, 8'h3F);
        check({1'b0, sec, qe, wpa, pza, rsa}, 8'h78);
        cmd(fsc_pkg::OP_QUAD);
        check({7'h00, fw}, 8'h01);
        wsr(fsc_pkg::OP_WRSR2, 8'h00);
        wait_idle();
        rsr(fsc_pkg::OP_RDSR2, 8'h3A);
        cmd(fsc_pkg::OP_QEXIT);
        $display("test protect fields done");
        for (int d = 0; d < 4; d++) begin
            wsr(fsc_pkg::OP_WRSR3, 8'(d * 32) | 8'h9F);
            wait_idle();
            rsr(fsc_pkg::OP_RDSR3, 8'(d * 32) | 8'h84);
            check({1'b0, pct}, d == 0 ? 8'h64 : d == 1 ? 8'h4B : d == 2 ? 8'h32 : 8'h19);
        end
        check({1'b0, ubl, reg_cfg}, 8'h40);
        wsr(fsc_pkg::OP_WRSR2, 8'h00);
        wait_idle();
        check({5'h00, qe, pza, rsa}, 8'h01);
        $display("test config fields done");
        do_reset();
        wsr(fsc_pkg::OP_WRSR1, 8'h80);
        wait_idle();
        check({7'h00, wpa}, 8'h01);
        i_wp_n = 1'b0;
        wsr(fsc_pkg::OP_WRSR1, 8'h00);
        check({7'h00, busy}, 8'h00);
        rsr(fsc_pkg::OP_RDSR1, 8'h82);
        i_wp_n = 1'b1;
        host.xfer(fsc_pkg::OP_WRSR1, 8'h00, 1'b1, rd);
        wait_idle();
        rsr(fsc_pkg::OP_RDSR1, 8'h00);
        for (int k = 0; k < 2; k++) begin
            // The prefix must sit right before the write, so enable comes first.
            cmd(fsc_pkg::OP_WREN);
            if (k == 1) cmd(fsc_pkg::PFX_ONE);
            if (k == 1) cmd(fsc_pkg::PFX_TWO);
            host.xfer(fsc_pkg::OP_WRSR2, 8'h01, 1'b1, rd);
            wait_idle();
            wsr(fsc_pkg::OP_WRSR2, 8'h00);
            rsr(fsc_pkg::OP_RDSR2, 8'h01);
            do_reset();
            rsr(fsc_pkg::OP_RDSR2, 8'h00);
        end
        $display("test write gating done");
        wsr(fsc_pkg::OP_WRSR1, 8'h04);
        cmd(fsc_pkg::OP_SUSP);
        rsr(fsc_pkg::OP_RDSR2, 8'h80);
        cmd(fsc_pkg::OP_RESUME);
        rsr(fsc_pkg::OP_RDSR2, 8'h00);
        wait_idle();
        rsr(fsc_pkg::OP_RDSR1, 8'h04);
        $display("test suspend done");
        give_verdict();
    end
endmodule
